// ### core/adc_pkg.sv
package adc_pkg;
    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_CTRL = 12'hF70;
    localparam logic [11:0] IDX_RES_HI = 12'hF72;
    localparam logic [11:0] IDX_RES_LO = 12'hF73;
    localparam logic [11:0] IDX_SETTLE = 12'hF74;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;

    // converter control field positions
    localparam int START_BIT = 7;
    localparam int REF_BIT = 5;
    localparam int ON_BIT = 4;
    localparam int CH_LSB = 0;
    localparam int CH_W = 3;
    localparam int RESV_HI_BIT = 6;
    localparam int RESV_LO_BIT = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // result layout
    localparam int RESULT_W = 10;
    localparam int LOW_W = 2;
    localparam int LOW_LSB = 6;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;

    // settling count
    localparam int SETTLE_W = 4;
    localparam logic [SETTLE_W-1:0] SETTLE_RESET = 4'hF;

    // timing at the system clock
    localparam int CLK_FREQ_MHZ = 100;
    localparam int SAMPLE_TIME_NS = 1000;
    localparam int SAMPLE_CYCLES = (SAMPLE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int CONV_CYCLES = 13;
    localparam int CNT_W = 8;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_SETTLE = 2'b10,
        ST_CONVERT = 2'b11
    } conv_state_t;
endpackage

// ### core/conv_if.sv
`timescale 1ns/1ps
interface conv_if;
    import adc_pkg::*;
    logic start;
    logic enable;
    logic [SETTLE_W-1:0] settle;
    logic busy;
    logic done;
    logic [RESULT_W-1:0] result;
    logic sample_phase;
    logic convert_phase;

    modport ctl (output start, output enable, output settle, input busy, input done,
        input result, input sample_phase, input convert_phase);
    modport seq (input start, input enable, input settle, output busy, output done,
        output result, output sample_phase, output convert_phase);
endinterface

// ### core/sync2.sv
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // two-stage synchroniser; only the second stage is read
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// ### core/conv_sequencer.sv
`timescale 1ns/1ps
module conv_sequencer
    import adc_pkg::*;
#(
    parameter int SAMPLE_CYC = SAMPLE_CYCLES,
    parameter int CONV_CYC = CONV_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [RESULT_W-1:0] analog_bits,
    conv_if.seq cv
);
    // refuse phase lengths that the phase counter cannot hold
    if (SAMPLE_CYC < 1 || SAMPLE_CYC >= 2**CNT_W || CONV_CYC < 1
        || CONV_CYC >= 2**CNT_W) begin
        $error("conv_sequencer: phase lengths must fit the phase counter");
    end

    localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_CYC - 1);
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);

    conv_state_t state_r;
    logic [CNT_W-1:0] cnt_r;
    logic [RESULT_W-1:0] result_r;
    logic done_r;
    logic finish;

    assign finish = (state_r == ST_CONVERT) && (cnt_r == '0) && !cv.start && cv.enable;

    // phase sequencing: sample, settle, then fixed-length conversion
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
        end else if (!cv.enable) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
        end else if (cv.start) begin
            state_r <= ST_SAMPLE; // restart even mid-conversion
            cnt_r <= SAMPLE_LAST;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    state_r <= ST_IDLE;
                end
                ST_SAMPLE: begin
                    if (cv.settle == '0) begin
                        state_r <= ST_CONVERT;
                        cnt_r <= CONV_LAST;
                    end else begin
                        state_r <= ST_SETTLE; // settle delay in clock periods
                        cnt_r <= CNT_W'(cv.settle) - 1'b1;
                    end
                end
                ST_SETTLE: begin
                    state_r <= ST_CONVERT;
                    cnt_r <= CONV_LAST; // conversion lasts CONV_CYC clocks
                end
                ST_CONVERT: begin
                    state_r <= ST_IDLE; // busy drops as the result lands
                end
            endcase
        end
    end

    // result replaced only when a conversion completes
    always_ff @(posedge clk) begin
        if (rst) begin
            result_r <= RESULT_RESET;
        end else if (finish) begin
            result_r <= analog_bits;
        end
    end

    // completion pulse raises the interrupt request
    always_ff @(posedge clk) begin
        if (rst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= finish;
        end
    end

    assign cv.busy = (state_r != ST_IDLE);
    assign cv.done = done_r;
    assign cv.result = result_r;
    assign cv.sample_phase = (state_r == ST_SAMPLE);
    assign cv.convert_phase = (state_r == ST_CONVERT);

    logic [CNT_W-1:0] conv_len_r;
    always_ff @(posedge clk) begin
        if (rst || state_r != ST_CONVERT) begin
            conv_len_r <= '0;
        end else begin
            conv_len_r <= conv_len_r + 1'b1;
        end
    end

    a_convert_length: assert property (@(posedge clk) disable iff (rst)
        finish |-> conv_len_r == CONV_LAST)
        else $error("conversion phase length wrong");

    a_done_clears_busy: assert property (@(posedge clk) disable iff (rst)
        finish |=> !cv.busy && done_r)
        else $error("busy not cleared with result");

    a_restart_sample: assert property (@(posedge clk) disable iff (rst)
        (cv.start && cv.enable) |=> state_r == ST_SAMPLE && cnt_r == SAMPLE_LAST)
        else $error("start did not restart sampling");
endmodule

// ### core/sar_adc_control_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - writing one to start/busy begins a new conversion
// - writing zero to start/busy changes nothing, conversion continues
// - start/busy reads one while converting, zero when free
// - reference enable bit 5 selects internal (1) or external (0) reference
// - converter enable bit 4 zero means disabled low power, one enabled
// - three-bit channel select routes analog input N to converter
// - result high register reads the upper eight result bits
// - reading result high captures the two low bits into result low
// - result holds until the next conversion completes
// - result low bits 7:6 carry the two least significant result bits
// - settling register sets delay from sample-and-hold to conversion
// - four-bit settling count in clock periods, resets to all ones
// - settling bits 7:4 read zero and are not writable
// - starting during a conversion abandons it and starts afresh
// - each finished conversion raises an interrupt; disabling keeps it
// - conversion phase lasts exactly 13 converter clocks
module sar_adc_control_regs
    import adc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic [2:0] AWPROT,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic [DATA_W/8-1:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic [2:0] ARPROT,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [DATA_W-1:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic [RESULT_W-1:0] ANALOG_BITS,
    output logic [CH_W-1:0] INPUT_CHANNEL_SELECT,
    output logic INTERNAL_REFERENCE_ON,
    output logic CONVERTER_ON,
    output logic SAMPLE_PHASE,
    output logic CONVERT_PHASE,
    output logic CONV_DONE_IRQ
);
    localparam logic [ADDR_W-3:0] WORD_CTRL = (ADDR_W-2)'(IDX_CTRL);
    localparam logic [ADDR_W-3:0] WORD_RES_HI = (ADDR_W-2)'(IDX_RES_HI);
    localparam logic [ADDR_W-3:0] WORD_RES_LO = (ADDR_W-2)'(IDX_RES_LO);
    localparam logic [ADDR_W-3:0] WORD_SETTLE = (ADDR_W-2)'(IDX_SETTLE);

    conv_if cv ();

    logic [RESULT_W-1:0] analog_sync;

    // analog core bits arrive unsynchronised
    sync2 #(
        .W(RESULT_W)
    ) u_sync (
        .clk(CLK),
        .rst(RST),
        .d(ANALOG_BITS),
        .q(analog_sync)
    );

    conv_sequencer u_seq (
        .clk(CLK),
        .rst(RST),
        .analog_bits(analog_sync),
        .cv(cv)
    );

    // write channel state
    logic aw_held_r;
    logic w_held_r;
    logic [ADDR_W-3:0] aw_word_r;
    logic [DATA_W-1:0] wdata_r;
    logic wstrb0_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic aw_take;
    logic w_take;
    logic wr_go;
    logic [ADDR_W-3:0] wr_word;
    logic [DATA_W-1:0] wr_data;
    logic wr_lane0;

    // register contents
    logic ctrl_resv_hi_r;
    logic ctrl_resv_lo_r;
    logic ref_on_r;
    logic conv_on_r;
    logic [CH_W-1:0] chan_r;
    logic [SETTLE_W-1:0] settle_r;
    logic [LOW_W-1:0] low_latch_r;
    logic start_r;

    // read channel state
    logic rvalid_r;
    logic [DATA_W-1:0] rdata_r;
    logic [1:0] rresp_r;
    logic ar_take;
    logic [ADDR_W-3:0] ar_word;
    logic [7:0] ctrl_view;

    assign AWREADY = !aw_held_r && !bvalid_r;
    assign WREADY = !w_held_r && !bvalid_r;
    assign aw_take = AWVALID && AWREADY;
    assign w_take = WVALID && WREADY;
    assign wr_go = (aw_take || aw_held_r) && (w_take || w_held_r);
    assign wr_word = aw_held_r ? aw_word_r : AWADDR[ADDR_W-1:2];
    assign wr_data = w_held_r ? wdata_r : WDATA;
    assign wr_lane0 = w_held_r ? wstrb0_r : WSTRB[0];

    // address and data are taken in either order, held until both present
    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_word_r <= '0;
            wdata_r <= '0;
            wstrb0_r <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_word_r <= AWADDR[ADDR_W-1:2];
            end
            if (w_take) begin
                wdata_r <= WDATA;
                wstrb0_r <= WSTRB[0];
            end
            aw_held_r <= !wr_go && (aw_held_r || aw_take);
            w_held_r <= !wr_go && (w_held_r || w_take);
        end
    end

    // write response, held until accepted
    always_ff @(posedge CLK) begin
        if (RST) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            unique case (wr_word)
                WORD_CTRL, WORD_RES_HI, WORD_RES_LO, WORD_SETTLE: bresp_r <= RESP_OKAY;
                default: bresp_r <= RESP_SLVERR;
            endcase
        end else if (BREADY) begin
            bvalid_r <= 1'b0;
        end
    end

    // converter control fields
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_resv_hi_r <= CTRL_RESET[RESV_HI_BIT];
            ref_on_r <= CTRL_RESET[REF_BIT];
            conv_on_r <= CTRL_RESET[ON_BIT];
            ctrl_resv_lo_r <= CTRL_RESET[RESV_LO_BIT];
            chan_r <= CTRL_RESET[CH_LSB +: CH_W];
        end else if (wr_go && wr_lane0 && wr_word == WORD_CTRL) begin
            ctrl_resv_hi_r <= wr_data[RESV_HI_BIT]; // kept as written
            ref_on_r <= wr_data[REF_BIT];
            conv_on_r <= wr_data[ON_BIT];
            ctrl_resv_lo_r <= wr_data[RESV_LO_BIT];
            chan_r <= wr_data[CH_LSB +: CH_W];
        end
    end

    // a one in the start bit launches; a zero is ignored
    always_ff @(posedge CLK) begin
        if (RST) begin
            start_r <= 1'b0;
        end else begin
            start_r <= wr_go && wr_lane0 && wr_word == WORD_CTRL
                && wr_data[START_BIT];
        end
    end

    // settling count; upper nibble has no storage
    always_ff @(posedge CLK) begin
        if (RST) begin
            settle_r <= SETTLE_RESET;
        end else if (wr_go && wr_lane0 && wr_word == WORD_SETTLE) begin
            settle_r <= wr_data[SETTLE_W-1:0];
        end
    end

    assign cv.start = start_r;
    assign cv.enable = conv_on_r;
    assign cv.settle = settle_r;

    assign ARREADY = !rvalid_r;
    assign ar_take = ARVALID && ARREADY;
    assign ar_word = ARADDR[ADDR_W-1:2];
    assign ctrl_view = {cv.busy, ctrl_resv_hi_r, ref_on_r, conv_on_r, ctrl_resv_lo_r, chan_r};

    // read data mux, answered one cycle after the address is taken
    always_ff @(posedge CLK) begin
        if (RST) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            unique case (ar_word)
                WORD_CTRL: rdata_r <= DATA_W'(ctrl_view);
                WORD_RES_HI: rdata_r <= DATA_W'(cv.result[RESULT_W-1:LOW_W]);
                WORD_RES_LO: rdata_r <= DATA_W'(low_latch_r) << LOW_LSB;
                WORD_SETTLE: rdata_r <= DATA_W'(settle_r);
                default: begin
                    rdata_r <= '0;
                    rresp_r <= RESP_SLVERR;
                end
            endcase
        end else if (RREADY) begin
            rvalid_r <= 1'b0;
        end
    end

    // reading the high byte latches the matching low bits
    always_ff @(posedge CLK) begin
        if (RST) begin
            low_latch_r <= RESULT_RESET[LOW_W-1:0]; // value not meaningful
        end else if (ar_take && ar_word == WORD_RES_HI) begin
            low_latch_r <= cv.result[LOW_W-1:0];
        end
    end

    assign BVALID = bvalid_r;
    assign BRESP = bresp_r;
    assign RVALID = rvalid_r;
    assign RDATA = rdata_r;
    assign RRESP = rresp_r;
    assign INPUT_CHANNEL_SELECT = chan_r;
    assign INTERNAL_REFERENCE_ON = ref_on_r;
    assign CONVERTER_ON = conv_on_r;
    assign SAMPLE_PHASE = cv.sample_phase;
    assign CONVERT_PHASE = cv.convert_phase;
    assign CONV_DONE_IRQ = cv.done; // pulse, unaffected by disable

    logic ctrl_wr;
    assign ctrl_wr = wr_go && wr_lane0 && wr_word == WORD_CTRL;

    a_start_launches: assert property (@(posedge CLK) disable iff (RST)
        (ctrl_wr && wr_data[START_BIT] && wr_data[ON_BIT]) |-> ##2 cv.busy ##0 SAMPLE_PHASE)
        else $error("start write did not launch a conversion");

    a_zero_keeps_busy: assert property (@(posedge CLK) disable iff (RST)
        (ctrl_wr && !wr_data[START_BIT] && wr_data[ON_BIT] && cv.busy && !CONVERT_PHASE)
        |=> ##1 cv.busy)
        else $error("zero start write cancelled conversion");

    a_busy_readback: assert property (@(posedge CLK) disable iff (RST)
        (ar_take && ar_word == WORD_CTRL) |=> RDATA[START_BIT] == $past(cv.busy))
        else $error("start/busy readback wrong");

    a_ref_follows: assert property (@(posedge CLK) disable iff (RST)
        ctrl_wr |=> INTERNAL_REFERENCE_ON == $past(wr_data[REF_BIT]))
        else $error("reference enable not applied");

    a_off_idles: assert property (@(posedge CLK) disable iff (RST)
        (!CONVERTER_ON && !start_r) |=> !cv.busy)
        else $error("disabled converter still busy");

    a_channel_route: assert property (@(posedge CLK) disable iff (RST)
        ctrl_wr |=> INPUT_CHANNEL_SELECT == $past(wr_data[CH_LSB +: CH_W]))
        else $error("channel select not applied");

    a_low_capture: assert property (@(posedge CLK) disable iff (RST)
        (ar_take && ar_word == WORD_RES_HI) |=> low_latch_r == $past(cv.result[LOW_W-1:0]))
        else $error("low bits not latched on high read");

    a_low_no_capture: assert property (@(posedge CLK) disable iff (RST)
        !(ar_take && ar_word == WORD_RES_HI) |=> $stable(low_latch_r))
        else $error("low bits changed without high read");

    a_result_stable: assert property (@(posedge CLK) disable iff (RST)
        !cv.done |-> $stable(cv.result))
        else $error("result changed outside completion");

    a_settle_upper: assert property (@(posedge CLK) disable iff (RST)
        (ar_take && ar_word == WORD_SETTLE)
        |=> RDATA[7:4] == 4'h0 && RDATA[SETTLE_W-1:0] == $past(settle_r))
        else $error("settling readback wrong");

    a_high_readback: assert property (@(posedge CLK) disable iff (RST)
        (ar_take && ar_word == WORD_RES_HI)
        |=> RDATA == DATA_W'($past(cv.result[RESULT_W-1:LOW_W])))
        else $error("result high readback wrong");

    a_low_readback: assert property (@(posedge CLK) disable iff (RST)
        (ar_take && ar_word == WORD_RES_LO)
        |=> RDATA[LOW_LSB +: LOW_W] == $past(low_latch_r) && RDATA[LOW_LSB-1:0] == '0)
        else $error("result low readback wrong");

    a_irq_one_pulse: assert property (@(posedge CLK) disable iff (RST)
        CONV_DONE_IRQ |=> !CONV_DONE_IRQ)
        else $error("completion pulse longer than one cycle");
endmodule

// ### tb/test_sar_adc_control_regs.sv
`timescale 1ns/1ps
module test_sar_adc_control_regs
    import adc_pkg::*;
;
    localparam logic [15:0] A_CTRL = {2'b00, IDX_CTRL, 2'b00};
    localparam logic [15:0] A_HI = {2'b00, IDX_RES_HI, 2'b00};
    localparam logic [15:0] A_LO = {2'b00, IDX_RES_LO, 2'b00};
    localparam logic [15:0] A_SET = {2'b00, IDX_SETTLE, 2'b00};
    localparam logic [15:0] A_NONE = 16'h3DC4; // index F71 holds no register

    logic CLK, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    logic ARVALID, ARREADY, RVALID, RREADY, INTERNAL_REFERENCE_ON, CONVERTER_ON;
    logic SAMPLE_PHASE, CONVERT_PHASE, CONV_DONE_IRQ;
    logic [ADDR_W-1:0] AWADDR, ARADDR;
    logic [DATA_W-1:0] WDATA, RDATA;
    logic [3:0] WSTRB;
    logic [1:0] BRESP, RRESP;
    logic [RESULT_W-1:0] ANALOG_BITS;
    logic [CH_W-1:0] INPUT_CHANNEL_SELECT;
    int fail_count = 0;
    int check_count = 0;
    int cyc = 0;
    int irq_n = 0;
    int irq_cyc = 0;
    int cp_run = 0;
    int cp_last = 0;
    int sp_end = 0;
    logic [3:0] strb = 4'hF;
    int n0, st, t0, t, i;
    logic [1:0] exp_b[$];
    logic [33:0] exp_r[$];
    logic [31:0] rnd = 32'hfeb0;
    logic [9:0] va, vb;
    logic [7:0] v;

    sar_adc_control_regs uut (.CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWPROT(3'b000),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
        .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARPROT(3'b000), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY), .ANALOG_BITS(ANALOG_BITS),
        .INPUT_CHANNEL_SELECT(INPUT_CHANNEL_SELECT), .INTERNAL_REFERENCE_ON(INTERNAL_REFERENCE_ON),
        .CONVERTER_ON(CONVERTER_ON), .SAMPLE_PHASE(SAMPLE_PHASE), .CONVERT_PHASE(CONVERT_PHASE),
        .CONV_DONE_IRQ(CONV_DONE_IRQ));

    // 100 MHz system clock
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run;
        if (fail_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // one write: address and data offered together, bready held until the response
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        bit done = 0;
        exp_b.push_back(r);
        @(posedge CLK);
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= strb;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        for (n = 0; n < 200 && !done; n++) begin
            @(posedge CLK);
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
            if (BVALID && BREADY) begin
                BREADY <= 1'b0;
                done = 1;
            end
        end
        chk("write handshake", 32'h1, {31'h0, done});
    endtask

    // one read; the expected response and data go to the queue
    task automatic rd(input logic [15:0] a, input logic [1:0] r, input logic [31:0] d);
        int n;
        bit done = 0;
        exp_r.push_back({r, d});
        @(posedge CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        for (n = 0; n < 200 && !done; n++) begin
            @(posedge CLK);
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
            if (RVALID && RREADY) begin
                RREADY <= 1'b0;
                done = 1;
            end
        end
        chk("read handshake", 32'h1, {31'h0, done});
    endtask

    task automatic start_conv(input logic [9:0] a);
        @(posedge CLK);
        ANALOG_BITS <= a;
        n0 = irq_n;
        wr(A_CTRL, 32'h0000_0090, RESP_OKAY);
        st = cyc;
    endtask

    task automatic wait_irq(output int tt);
        int n;
        for (n = 0; n < 600 && irq_n == n0; n++) @(posedge CLK);
        chk("conversion done", 32'h1, {31'h0, irq_n != n0});
        tt = irq_cyc - st;
        chk("convert phase length", 32'd13, cp_last);
        chk("sample phase length", SAMPLE_CYCLES, sp_end - st);
    endtask

    task automatic result_ok(input logic [9:0] a);
        rd(A_HI, RESP_OKAY, {24'h0, a[9:2]});
        rd(A_LO, RESP_OKAY, {24'h0, a[1:0], 6'h00});
    endtask

    // response watcher: takes the oldest note whenever a response is handed over
    always @(posedge CLK) begin
        if (BVALID && BREADY) begin
            chk("bresp", {30'h0, exp_b.pop_front()}, {30'h0, BRESP});
        end
        if (RVALID && RREADY) begin
            chk("rresp", {30'h0, exp_r[0][33:32]}, {30'h0, RRESP});
            chk("rdata", exp_r[0][31:0], RDATA);
            void'(exp_r.pop_front());
        end
    end

    // cycle count, conversion phase length and completion pulses
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (CONVERT_PHASE === 1'b1) begin
            cp_run <= cp_run + 1;
        end else if (cp_run != 0) begin
            cp_last <= cp_run;
            cp_run <= 0;
        end
        if (SAMPLE_PHASE === 1'b1) begin
            sp_end <= cyc;
        end
        if (CONV_DONE_IRQ === 1'b1) begin
            irq_n <= irq_n + 1;
            irq_cyc <= cyc;
        end
    end

    // watchdog against a hung handshake
    initial begin
        #(10 * 20000);
        fail_count++;
        complete_run();
    end

    initial begin
        RST = 1'b1;
        {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
        AWADDR = 16'h0000;
        ARADDR = 16'h0000;
        WDATA = 32'h0000_0000;
        WSTRB = 4'h0;
        ANALOG_BITS = 10'h000;
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        rd(A_CTRL, RESP_OKAY, 32'h0000_0000);
        rd(A_SET, RESP_OKAY, 32'h0000_000F);
        rd(A_NONE, RESP_SLVERR, 32'h0000_0000);
        wr(A_NONE, 32'h0000_00FF, RESP_SLVERR);
        wr(A_SET, 32'h0000_00FF, RESP_OKAY);
        rd(A_SET, RESP_OKAY, 32'h0000_000F);
        // a write without byte lane zero is dropped
        strb = 4'hE;
        wr(A_SET, 32'h0000_0005, RESP_OKAY);
        strb = 4'hF;
        rd(A_SET, RESP_OKAY, 32'h0000_000F);
        // every channel, with reference and enable in all four pairings
        for (i = 0; i < 8; i++) begin
            v = {2'b00, i[0], i[1], 1'b0, i[2:0]};
            wr(A_CTRL, {24'h0, v}, RESP_OKAY);
            @(posedge CLK);
            chk("channel", i, {29'h0, INPUT_CHANNEL_SELECT});
            chk("reference", {31'h0, i[0]}, {31'h0, INTERNAL_REFERENCE_ON});
            chk("enable", {31'h0, i[1]}, {31'h0, CONVERTER_ON});
            rd(A_CTRL, RESP_OKAY, {24'h0, v});
        end
        // reference conversion with no settling
        wr(A_SET, 32'h0000_0000, RESP_OKAY);
        rnd = xs(rnd);
        va = rnd[9:0];
        start_conv(va);
        repeat (5) @(posedge CLK);
        rd(A_CTRL, RESP_OKAY, 32'h0000_0090);
        wait_irq(t0);
        rd(A_CTRL, RESP_OKAY, 32'h0000_0010);
        result_ok(va);
        @(posedge CLK);
        ANALOG_BITS <= ~va;
        repeat (10) @(posedge CLK);
        rd(A_HI, RESP_OKAY, {24'h0, va[9:2]});
        // longest settling adds fifteen cycles; low bits stay latched until a high read
        wr(A_SET, 32'h0000_000F, RESP_OKAY);
        rnd = xs(rnd);
        vb = rnd[9:0];
        start_conv(vb);
        wait_irq(t);
        chk("settle 15 delay", t0 + 15, t);
        rd(A_LO, RESP_OKAY, {24'h0, va[1:0], 6'h00});
        result_ok(vb);
        wr(A_SET, 32'h0000_0003, RESP_OKAY);
        rnd = xs(rnd);
        vb = rnd[9:0];
        start_conv(vb);
        wait_irq(t);
        chk("settle 3 delay", t0 + 3, t);
        result_ok(vb);
        // result low is read-only; a zero write leaves the latch alone
        wr(A_LO, 32'h0000_0000, RESP_OKAY);
        rd(A_LO, RESP_OKAY, {24'h0, vb[1:0], 6'h00});
        // writing zero to start leaves the conversion running
        wr(A_SET, 32'h0000_0000, RESP_OKAY);
        rnd = xs(rnd);
        vb = rnd[9:0];
        start_conv(vb);
        repeat (30) @(posedge CLK);
        wr(A_CTRL, 32'h0000_0010, RESP_OKAY);
        wait_irq(t);
        chk("zero start keeps timing", t0, t);
        result_ok(vb);
        // a second start restarts; only one completion follows
        rnd = xs(rnd);
        vb = rnd[9:0];
        start_conv(vb);
        repeat (40) @(posedge CLK);
        wr(A_CTRL, 32'h0000_0090, RESP_OKAY);
        st = cyc;
        wait_irq(t);
        chk("restart timing", t0, t);
        repeat (200) @(posedge CLK);
        chk("one completion", n0 + 1, irq_n);
        result_ok(vb);
        // start while disabled does nothing
        n0 = irq_n;
        wr(A_CTRL, 32'h0000_0080, RESP_OKAY);
        repeat (200) @(posedge CLK);
        chk("disabled start", n0, irq_n);
        chk("disabled output", 32'h0, {31'h0, CONVERTER_ON});
        rd(A_CTRL, RESP_OKAY, 32'h0000_0000);
        complete_run();
    end
endmodule
